// *** prescaled_timer_pkg.sv ***
// Package with register map, field layout and timing constants of the prescaled timer.
package prescaled_timer_pkg;

  // Special-function register addresses (values are ours; the map leaves them open).
  localparam logic [7:0] ADDR_RELOAD_LOW = 8'hE0;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hE1;
  localparam logic [7:0] ADDR_PRESCALE_RELOAD = 8'hE2;
  localparam logic [7:0] ADDR_CONTROL_STATUS = 8'hE3;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'hE4;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'hE5;

  // Control/status field positions.
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_OVERFLOW_BIT = 1;

  // Reset values.
  localparam logic [7:0] RELOAD_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;

  // Unmapped reads return this value.
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Machine cycle timing.
  localparam int CLOCK_MHZ = 125;
  localparam int MACHINE_CYCLE_NS = 1000;
  localparam int CLOCK_PERIOD_NS = 1000 / CLOCK_MHZ;
  localparam int MACHINE_CYCLE_CLOCKS = MACHINE_CYCLE_NS / CLOCK_PERIOD_NS;

  // Interrupt vector of the overflow source.
  localparam logic [15:0] TIMER_IRQ_VECTOR = 16'h003B;

  // Special-function register bus request.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  // Interrupt request towards the interrupt controller.
  typedef struct packed {
    logic req;
    logic [15:0] vector;
  } irq_req_t;

endpackage : prescaled_timer_pkg

// *** machine_cycle_tick.sv ***
// Divider that produces one pulse per machine cycle from the core clock.
`timescale 1ns/1ns
module machine_cycle_tick
  import prescaled_timer_pkg::*;
#(
  parameter int CYCLE_CLOCKS = MACHINE_CYCLE_CLOCKS
) (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Tick output.
  output logic o_tick
);

  localparam int W = $clog2(CYCLE_CLOCKS + 1);
  localparam logic [W-1:0] LAST = W'(CYCLE_CLOCKS - 1);
  localparam logic [W-1:0] ZERO = '0;
  localparam logic [W-1:0] ONE = W'(1);

  logic [W-1:0] div_q;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      div_q <= ZERO;
    end else if (div_q == LAST) begin
      div_q <= ZERO;
    end else begin
      div_q <= div_q + ONE;
    end
  end

  assign o_tick = (div_q == LAST);

endmodule : machine_cycle_tick

// *** reload_counter.sv ***
// Loadable 8-bit counter stage with carry in and carry out.
`timescale 1ns/1ns
module reload_counter #(
  parameter int WIDTH = 8
) (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Control.
  input wire logic i_count,
  input wire logic i_load,
  input wire logic [WIDTH-1:0] i_load_value,
  // Status.
  output logic [WIDTH-1:0] o_value,
  output logic o_carry
);

  localparam logic [WIDTH-1:0] ONES = '1;
  localparam logic [WIDTH-1:0] ZERO = '0;
  localparam logic [WIDTH-1:0] ONE = WIDTH'(1);

  logic [WIDTH-1:0] value_q;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      value_q <= ZERO;
    end else if (i_load) begin
      value_q <= i_load_value;
    end else if (i_count) begin
      value_q <= value_q + ONE;
    end
  end

  assign o_value = value_q;
  assign o_carry = i_count && (value_q == ONES);

endmodule : reload_counter

// *** prescaled_interval_timer.sv ***
// Interval timer with an 8-bit prescaler, reload registers and overflow interrupt.
//
// Operation
// - A 16-bit timer is driven through an 8-bit prescaler for periods up to about 16.777 s.
// - The timer keeps counting while the processor core is idle.
// - The prescaler advances once per machine cycle of 125 core clock periods, 1 MHz.
// - Control/status bit 0 enables the timer and bit 1 reports overflow.
// - The overflow bit is set to one when the count wraps from all ones; zero means no overflow.
// - Hardware never clears the overflow bit; software clears it after each overflow.
// - Every overflow raises an interrupt request to the processor.
// - On overflow the prescaler and both timer bytes reload and counting continues.
// - Reload registers change only on software writes and read back the written value.
// - Two read-only registers show the current low and high count in any state.
// - When disabled, the current count freezes at the value it had when disabled.
// - The overflow interrupt is its own source, lowest in polling order, with its own vector.
`timescale 1ns/1ns
module prescaled_interval_timer
  import prescaled_timer_pkg::*;
#(
  parameter int PRESCALE_WIDTH = 8,
  parameter int TIMER_WIDTH = 16
) (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Core idle indication, which does not stop the timer.
  input wire logic i_core_idle,
  // Special-function register access.
  input wire sfr_req_t i_sfr,
  output logic [7:0] o_sfr_rdata,
  // Overflow interrupt request.
  output irq_req_t o_irq
);

  localparam int HALF = TIMER_WIDTH / 2;

  // Software-visible storage.
  logic [7:0] reload_low_byte_q;
  logic [7:0] reload_high_byte_q;
  logic [7:0] prescale_reload_q;
  logic enable_q;
  logic overflow_q;
  logic irq_q;
  logic [7:0] rdata_q;

  // Chain signals.
  logic tick;
  logic advance;
  logic pre_carry;
  logic low_carry;
  logic high_carry;
  logic chain_wrap;
  logic [PRESCALE_WIDTH-1:0] pre_value;
  logic [HALF-1:0] low_value;
  logic [HALF-1:0] high_value;

  // Decoded writes.
  logic wr_ctrl;
  logic unused_idle;

  assign unused_idle = i_core_idle;
  assign wr_ctrl = i_sfr.wr && (i_sfr.addr == ADDR_CONTROL_STATUS);

  machine_cycle_tick #(
    .CYCLE_CLOCKS(MACHINE_CYCLE_CLOCKS)
  ) u_tick (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .o_tick(tick)
  );

  assign advance = tick && enable_q;

  reload_counter #(
    .WIDTH(PRESCALE_WIDTH)
  ) u_prescale (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_count(advance),
    .i_load(chain_wrap),
    .i_load_value(prescale_reload_q[PRESCALE_WIDTH-1:0]),
    .o_value(pre_value),
    .o_carry(pre_carry)
  );

  reload_counter #(
    .WIDTH(HALF)
  ) u_low (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_count(pre_carry),
    .i_load(chain_wrap),
    .i_load_value(reload_low_byte_q[HALF-1:0]),
    .o_value(low_value),
    .o_carry(low_carry)
  );

  reload_counter #(
    .WIDTH(HALF)
  ) u_high (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_count(low_carry),
    .i_load(chain_wrap),
    .i_load_value(reload_high_byte_q[HALF-1:0]),
    .o_value(high_value),
    .o_carry(high_carry)
  );

  // whole chain wrap; reload on it
  assign chain_wrap = high_carry;

  // reload registers written only by software
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      reload_low_byte_q <= RELOAD_RESET;
      reload_high_byte_q <= RELOAD_RESET;
      prescale_reload_q <= RELOAD_RESET;
    end else if (i_sfr.wr) begin
      if (i_sfr.addr == ADDR_RELOAD_LOW) begin
        reload_low_byte_q <= i_sfr.wdata;
      end
      if (i_sfr.addr == ADDR_RELOAD_HIGH) begin
        reload_high_byte_q <= i_sfr.wdata;
      end
      if (i_sfr.addr == ADDR_PRESCALE_RELOAD) begin
        prescale_reload_q <= i_sfr.wdata;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      enable_q <= 1'b0;
    end else if (wr_ctrl) begin
      enable_q <= i_sfr.wdata[CTRL_ENABLE_BIT];
    end
  end

  // Overflow flag: a wrap in the same cycle as a clear keeps the flag set.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      overflow_q <= 1'b0;
    end else if (chain_wrap) begin
      overflow_q <= 1'b1;
    // clear by writing zero; only software clears
    end else if (wr_ctrl && !i_sfr.wdata[CTRL_OVERFLOW_BIT]) begin
      overflow_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= chain_wrap;
    end
  end

  assign o_irq.req = irq_q;
  assign o_irq.vector = TIMER_IRQ_VECTOR;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      rdata_q <= UNMAPPED_READ;
    end else if (i_sfr.rd) begin
      case (i_sfr.addr)
        ADDR_RELOAD_LOW: rdata_q <= reload_low_byte_q;
        ADDR_RELOAD_HIGH: rdata_q <= reload_high_byte_q;
        ADDR_PRESCALE_RELOAD: rdata_q <= prescale_reload_q;
        ADDR_CONTROL_STATUS: begin
          rdata_q <= UNMAPPED_READ;
          rdata_q[CTRL_ENABLE_BIT] <= enable_q;
          rdata_q[CTRL_OVERFLOW_BIT] <= overflow_q;
        end
        ADDR_COUNT_LOW: rdata_q <= 8'(low_value);
        ADDR_COUNT_HIGH: rdata_q <= 8'(high_value);
        default: rdata_q <= UNMAPPED_READ;
      endcase
    end
  end

  assign o_sfr_rdata = rdata_q;

endmodule : prescaled_interval_timer

// *** prescaled_timer_properties.sv ***
// Port-level checker for the prescaled interval timer.
`timescale 1ns/1ns
module prescaled_timer_checker
  import prescaled_timer_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire sfr_req_t i_sfr,
  input wire logic [7:0] o_sfr_rdata,
  input wire irq_req_t o_irq
);
  logic flag_seen_q;
  wire rd_ctrl = i_sfr.rd && i_sfr.addr == ADDR_CONTROL_STATUS;
  wire clr_ctrl = i_sfr.wr && i_sfr.addr == ADDR_CONTROL_STATUS &&
    !i_sfr.wdata[CTRL_OVERFLOW_BIT];
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || clr_ctrl) begin
      flag_seen_q <= 1'b0;
    end else if (o_irq.req) begin
      flag_seen_q <= 1'b1;
    end
  end
  a_irq_pulse: assert property (o_irq.req |=> !o_irq.req)
    else $error("irq wider than one cycle");
  a_irq_spacing: assert property ($rose(o_irq.req) |=> !o_irq.req [*8])
    else $error("irq repeats too soon");
  a_irq_vector: assert property (o_irq.vector == TIMER_IRQ_VECTOR)
    else $error("irq vector wrong");
  a_ctrl_fields: assert property (rd_ctrl |=> o_sfr_rdata[7:2] == 6'h00)
    else $error("control spare bits set");
  a_flag_sticky: assert property (rd_ctrl && !i_sfr.wr && flag_seen_q |=> o_sfr_rdata[1])
    else $error("flag lost without clear");
  a_rdata_hold: assert property (!i_sfr.rd |=> $stable(o_sfr_rdata))
    else $error("read data moved");
  a_reload_readback: assert property (i_sfr.wr && i_sfr.addr == ADDR_RELOAD_HIGH ##1
    rd_ctrl == 1'b0 && i_sfr.rd && !i_sfr.wr && i_sfr.addr == ADDR_RELOAD_HIGH
    |=> o_sfr_rdata == $past(i_sfr.wdata, 2))
    else $error("reload readback wrong");
  a_reset_quiet: assert property (disable iff (1'b0) !i_rst_n |=>
    o_sfr_rdata == 8'h00 && !o_irq.req)
    else $error("outputs active in reset");
endmodule : prescaled_timer_checker
bind prescaled_interval_timer prescaled_timer_checker u_prescaled_timer_checker (
  .i_clock(i_clock), .i_rst_n(i_rst_n), .i_sfr(i_sfr),
  .o_sfr_rdata(o_sfr_rdata), .o_irq(o_irq));

// *** tb.sv ***
// Self-checking bench for the prescaled interval timer.
`timescale 1ns/1ns
module tb;
  import prescaled_timer_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_core_idle = 1'b0;
  sfr_req_t i_sfr = '0;
  logic [7:0] o_sfr_rdata;
  irq_req_t o_irq;
  logic [7:0] exp_q[$];
  logic took = 1'b0;
  logic [7:0] r;
  int err_total = 0;
  int check_count = 0;
  int k;
  always #4 i_clock = ~i_clock;
  prescaled_interval_timer #(.PRESCALE_WIDTH(1), .TIMER_WIDTH(8)) u_prescaled_interval_timer (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_core_idle(i_core_idle),
    .i_sfr(i_sfr), .o_sfr_rdata(o_sfr_rdata), .o_irq(o_irq));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic idle(input int n);
    i_sfr = '0;
    repeat (n) @(negedge i_clock);
  endtask : idle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_sfr = '{1'b1, 1'b0, a, d};
    @(negedge i_clock);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_sfr = '{1'b0, 1'b1, a, 8'h00};
    @(negedge i_clock);
  endtask : rd
  task automatic wait_irq(input int lim);
    k = 0;
    while (o_irq.req !== 1'b1 && k < lim) begin
      @(negedge i_clock);
      k++;
    end
    chk("irq", 16'h0001, {15'h0000, o_irq.req});
    chk("vector", TIMER_IRQ_VECTOR, o_irq.vector);
  endtask : wait_irq
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  always @(posedge i_clock) took <= i_sfr.rd;
  always @(negedge i_clock) begin
    if (took) chk("rdata", {8'h00, exp_q.pop_front()}, {8'h00, o_sfr_rdata});
  end
  initial begin
    r = 8'($urandom(95965));
    repeat (4) @(negedge i_clock);
    i_rst_n = 1'b1;
    for (int i = 0; i < 6; i++) rd(ADDR_RELOAD_LOW + 8'(i), 8'h00);
    rd(8'h7F, UNMAPPED_READ);
    wr(ADDR_RELOAD_HIGH, r);
    rd(ADDR_RELOAD_HIGH, r);
    wr(ADDR_COUNT_LOW, 8'h5A);
    rd(ADDR_COUNT_LOW, COUNT_RESET);
    wr(ADDR_CONTROL_STATUS, 8'h02);
    rd(ADDR_CONTROL_STATUS, 8'h00);
    $display("end register test");
    i_core_idle = 1'b1;
    wr(ADDR_CONTROL_STATUS, 8'h01);
    idle(125 * 20);
    wr(ADDR_CONTROL_STATUS, 8'h00);
    idle(300);
    rd(ADDR_COUNT_LOW, 8'h0A);
    $display("end freeze test");
    wr(ADDR_RELOAD_LOW, 8'hFF);
    wr(ADDR_RELOAD_HIGH, 8'hFF);
    wr(ADDR_PRESCALE_RELOAD, 8'hFF);
    wr(ADDR_CONTROL_STATUS, 8'h01);
    idle(1);
    wait_irq(500 * 125);
    rd(ADDR_COUNT_LOW, 8'h0F);
    rd(ADDR_CONTROL_STATUS, 8'h03);
    idle(1);
    wait_irq(130);
    wr(ADDR_CONTROL_STATUS, 8'h03);
    rd(ADDR_CONTROL_STATUS, 8'h03);
    wr(ADDR_CONTROL_STATUS, 8'h01);
    rd(ADDR_CONTROL_STATUS, 8'h01);
    idle(2);
    $display("end overflow test");
    finish_test();
  end
  initial begin
    #700000;
    err_total++;
    finish_test();
  end
endmodule : tb
